// ===== common/motor_mask_pkg.sv
// constants, field layouts and carrier types for the motor gate mask steering block
// Function
// - Mask logic offers normal, brake and protection modes; normal splits hardware/software masking.
// - Side-select 0 puts PWM on low-side transistors, 1 on high-side transistors.
// - PWM output enable 0 keeps every PWM waveform off all six outputs.
// - Hardware masking: pair-style 0 gives complementary PWM, 1 non-complementary.
// - Software masking ignores pair-style; mask enable and mask data set outputs.
// - Mask-source bit 0 selects hardware masking, 1 selects software masking.
// - Protection: high sides 0; low sides 0 or 1 per protect-style bit.
// - Status bits 5..3 show phase A high, A low, B high gate levels; reset 0.
// - Status bits 2..0 show filtered Hall C, B, A; reset value undefined.
// - Complementary low-side PWM, low command only: high gets inverted, low true PWM.
// - Complementary high-side PWM, high command only: high gets true, low inverted PWM.
// - Opposite-side command alone drives static levels: low-side PWM 1/0, high-side 0/1.
// - Non-complementary low-side PWM, low command only: high 0, low true PWM.
// - Brake outranks every mode: high sides off, low sides on.
package motor_mask_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CONFIG      = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS      = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MASK_ENABLE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_MASK_DATA   = 4'h3;

    // ************************************************************
    // config fields
    // ************************************************************
    localparam int unsigned CFG_SIDE_BIT    = 0;
    localparam int unsigned CFG_PROTECT_BIT = 1;
    localparam int unsigned CFG_ENABLE_BIT  = 2;
    localparam int unsigned CFG_PAIR_BIT    = 3;
    localparam int unsigned CFG_SOURCE_BIT  = 7;
    localparam logic [7:0] CFG_WRITE_MASK   = 8'h8F;
    localparam logic [7:0] CFG_RESET        = 8'h00;

    // ************************************************************
    // status fields and soft mask layout
    // ************************************************************
    localparam int unsigned STS_HALL_LSB    = 0;
    localparam int unsigned STS_B_HIGH_BIT  = 3;
    localparam int unsigned STS_A_LOW_BIT   = 4;
    localparam int unsigned STS_A_HIGH_BIT  = 5;
    localparam int unsigned MASK_W          = 6;
    localparam logic [MASK_W-1:0] MASK_RESET = 6'h00;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    // ************************************************************
    // carrier types
    // ************************************************************
    // high and low command of one phase
    typedef struct packed {
        logic high;
        logic low;
    } phase_cmd_t;

    // true and inverted output of one pwm channel
    typedef struct packed {
        logic true_out;
        logic inv_out;
    } pwm_pair_t;

    // high and low gate level of one phase
    typedef struct packed {
        logic high;
        logic low;
    } gate_t;

    // operating mode, gray coded
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_PROTECT = 2'h1,
        MODE_BRAKE   = 2'h3
    } mask_mode_t;

    localparam gate_t GATE_OFF   = 2'h0;
    localparam gate_t GATE_BRAKE = 2'h1;

endpackage

// ===== core/motor_gate_mask_steering.sv
// gate mask steering for a three-phase bridge with its register port
module motor_gate_mask_steering #(
    parameter int unsigned PHASES = 3
) (
    // clock and reset
    input  wire logic                               clk_sys,
    input  wire logic                               rst,
    // register port
    input  wire logic [motor_mask_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]                         reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [7:0]                         reg_rdata,
    // commutation commands, index 0 = phase A
    input  wire motor_mask_pkg::phase_cmd_t [PHASES-1:0] phase_cmd,
    // pwm channels, index 0 = channel 0
    input  wire motor_mask_pkg::pwm_pair_t  [PHASES-1:0] pwm_chan,
    // mode requests from the protection logic
    input  wire logic                               brake_request,
    input  wire logic                               protect_trip,
    // filtered hall inputs, index 0 = hall A
    input  wire logic [2:0]                         hall_filtered,
    // gate outputs
    output logic                                    gate_a_high_pin,
    output logic                                    gate_a_low_pin,
    output logic                                    gate_b_high_pin,
    output logic                                    gate_b_low_pin,
    output logic                                    gate_c_high_pin,
    output logic                                    gate_c_low_pin
);

    // ************************************************************
    // register state
    // ************************************************************
    logic [7:0]                               motor_ctrl_config;
    logic [motor_mask_pkg::MASK_W-1:0]        soft_mask_enable_reg;
    logic [motor_mask_pkg::MASK_W-1:0]        soft_mask_data_reg;
    logic [7:0]                               motor_ctrl_status;
    motor_mask_pkg::gate_t [PHASES-1:0]       gate_q;
    motor_mask_pkg::gate_t [PHASES-1:0]       next_gate;
    motor_mask_pkg::mask_mode_t               mode;

    // config field views
    logic side_sel;
    logic protect_style;
    logic pwm_en;
    logic pair_style;
    logic source_sel;

    assign side_sel      = motor_ctrl_config[motor_mask_pkg::CFG_SIDE_BIT];
    assign protect_style = motor_ctrl_config[motor_mask_pkg::CFG_PROTECT_BIT];
    assign pwm_en        = motor_ctrl_config[motor_mask_pkg::CFG_ENABLE_BIT];
    assign pair_style    = motor_ctrl_config[motor_mask_pkg::CFG_PAIR_BIT];
    assign source_sel    = motor_ctrl_config[motor_mask_pkg::CFG_SOURCE_BIT];

    // ************************************************************
    // steering function
    // ************************************************************
    // hardware steering of one phase; disabled pwm is replaced by full-on
    function automatic motor_mask_pkg::gate_t steer(
        input motor_mask_pkg::phase_cmd_t cmd,
        input motor_mask_pkg::pwm_pair_t  pwm,
        input logic                       side,
        input logic                       noncomp,
        input logic                       en
    );
        motor_mask_pkg::gate_t g;
        logic p;
        logic pb;
        g  = motor_mask_pkg::GATE_OFF;
        p  = en ? pwm.true_out : 1'h1;
        pb = en ? pwm.inv_out : 1'h0;
        if (cmd.high == cmd.low) begin
            g = motor_mask_pkg::GATE_OFF;
        end else if (cmd.low) begin
            // pwm lands on the side picked by the side select
            if (side) begin
                g = '{high: 1'h0, low: 1'h1};
            end else if (noncomp) begin
                g = '{high: 1'h0, low: p};
            end else begin
                g = '{high: pb, low: p};
            end
        end else begin
            if (!side) begin
                g = '{high: 1'h1, low: 1'h0};
            end else if (noncomp) begin
                g = '{high: p, low: 1'h0};
            end else begin
                g = '{high: p, low: pb};
            end
        end
        return g;
    endfunction

    // ************************************************************
    // mode selection
    // ************************************************************
    // brake outranks protection, protection outranks normal
    always_comb begin
        if (brake_request) begin
            mode = motor_mask_pkg::MODE_BRAKE;
        end else if (protect_trip) begin
            mode = motor_mask_pkg::MODE_PROTECT;
        end else begin
            mode = motor_mask_pkg::MODE_NORMAL;
        end
    end

    // ************************************************************
    // per-phase next gate levels
    // ************************************************************
    genvar ph;
    generate
        for (ph = 0; ph < PHASES; ph++) begin : g_phase
            motor_mask_pkg::gate_t hw_gate;
            motor_mask_pkg::gate_t sw_gate;
            motor_mask_pkg::gate_t normal_gate;
            logic                  en_h;
            logic                  en_l;

            // same function on every phase and its own channel
            assign hw_gate = steer(phase_cmd[ph], pwm_chan[ph], side_sel,
                                   pair_style & ~source_sel, pwm_en);

            assign en_h = soft_mask_enable_reg[2*ph];
            assign en_l = soft_mask_enable_reg[2*ph+1];

            // masked outputs take mask data; both masked high is forced off
            always_comb begin
                sw_gate.high = en_h ? soft_mask_data_reg[2*ph] : hw_gate.high;
                sw_gate.low  = en_l ? soft_mask_data_reg[2*ph+1] : hw_gate.low;
                if (en_h && en_l && sw_gate.high && sw_gate.low) begin
                    sw_gate = motor_mask_pkg::GATE_OFF;
                end
            end

            assign normal_gate = source_sel ? sw_gate : hw_gate;

            // mode override
            always_comb begin
                case (mode)
                    motor_mask_pkg::MODE_BRAKE: begin
                        next_gate[ph] = motor_mask_pkg::GATE_BRAKE;
                    end
                    motor_mask_pkg::MODE_PROTECT: begin
                        next_gate[ph] = '{high: 1'h0, low: protect_style};
                    end
                    default: begin
                        next_gate[ph] = normal_gate;
                    end
                endcase
            end
        end
    endgenerate

    // ************************************************************
    // gate output flops
    // ************************************************************
    // registered gate levels, all off in reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gate_q <= '0;
        end else begin
            gate_q <= next_gate;
        end
    end

    assign gate_a_high_pin = gate_q[0].high;
    assign gate_a_low_pin  = gate_q[0].low;
    assign gate_b_high_pin = gate_q[1].high;
    assign gate_b_low_pin  = gate_q[1].low;
    assign gate_c_high_pin = gate_q[2].high;
    assign gate_c_low_pin  = gate_q[2].low;

    // ************************************************************
    // register writes
    // ************************************************************
    // config: only implemented bits store
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            motor_ctrl_config <= motor_mask_pkg::CFG_RESET;
        end else if (reg_wr && reg_addr == motor_mask_pkg::OFS_CONFIG) begin
            motor_ctrl_config <= reg_wdata & motor_mask_pkg::CFG_WRITE_MASK;
        end
    end

    // soft mask enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            soft_mask_enable_reg <= motor_mask_pkg::MASK_RESET;
        end else if (reg_wr && reg_addr == motor_mask_pkg::OFS_MASK_ENABLE) begin
            soft_mask_enable_reg <= reg_wdata[motor_mask_pkg::MASK_W-1:0];
        end
    end

    // soft mask data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            soft_mask_data_reg <= motor_mask_pkg::MASK_RESET;
        end else if (reg_wr && reg_addr == motor_mask_pkg::OFS_MASK_DATA) begin
            soft_mask_data_reg <= reg_wdata[motor_mask_pkg::MASK_W-1:0];
        end
    end

    // ************************************************************
    // status and read path
    // ************************************************************
    // status view; unused bits zero, hall bits follow the filter
    always_comb begin
        motor_ctrl_status = motor_mask_pkg::READ_ZERO;
        motor_ctrl_status[motor_mask_pkg::STS_A_HIGH_BIT] = gate_q[0].high;
        motor_ctrl_status[motor_mask_pkg::STS_A_LOW_BIT]  = gate_q[0].low;
        motor_ctrl_status[motor_mask_pkg::STS_B_HIGH_BIT] = gate_q[1].high;
        motor_ctrl_status[motor_mask_pkg::STS_HALL_LSB +: 3] = hall_filtered;
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= motor_mask_pkg::READ_ZERO;
        end else if (!reg_rd) begin
            reg_rdata <= motor_mask_pkg::READ_ZERO;
        end else if (reg_addr == motor_mask_pkg::OFS_CONFIG) begin
            reg_rdata <= motor_ctrl_config;
        end else if (reg_addr == motor_mask_pkg::OFS_STATUS) begin
            reg_rdata <= motor_ctrl_status;
        end else if (reg_addr == motor_mask_pkg::OFS_MASK_ENABLE) begin
            reg_rdata <= {2'h0, soft_mask_enable_reg};
        end else if (reg_addr == motor_mask_pkg::OFS_MASK_DATA) begin
            reg_rdata <= {2'h0, soft_mask_data_reg};
        end else begin
            reg_rdata <= motor_mask_pkg::READ_ZERO;
        end
    end

endmodule // motor_gate_mask_steering

// ===== dv/gate_driver_model.sv
// behavioural gate driver transistor pairs that flag a shoot-through
module gate_driver_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // gate levels, pairs of {high,low} for phases c, b, a
    input  wire logic [5:0] gate_levels,
    // sticky flag, both transistors of one pair on
    output logic            shoot_through
);
    timeunit 1ns;
    timeprecision 1ps;
    // a pair conducting on both sides shorts the supply
    always_ff @(posedge clk_sys) begin
        if (rst)
            shoot_through <= 1'h0;
        else if (|(gate_levels & (gate_levels >> 1) & 6'h15))
            shoot_through <= 1'h1;
    end
endmodule // gate_driver_model

// ===== dv/motor_gate_mask_steering_monitor.sv
// assertion checker for the gate mask steering ports
module motor_gate_mask_steering_monitor #(
    parameter int unsigned PHASES = 3
) (
    // clock, reset and register port
    input wire logic                                    clk_sys,
    input wire logic                                    rst,
    input wire logic [motor_mask_pkg::ADDR_W-1:0]       reg_addr,
    input wire logic [7:0]                              reg_wdata,
    input wire logic                                    reg_wr,
    input wire logic                                    reg_rd,
    input wire logic [7:0]                              reg_rdata,
    // steering inputs
    input wire motor_mask_pkg::phase_cmd_t [PHASES-1:0] phase_cmd,
    input wire motor_mask_pkg::pwm_pair_t  [PHASES-1:0] pwm_chan,
    input wire logic                                    brake_request,
    input wire logic                                    protect_trip,
    input wire logic [2:0]                              hall_filtered,
    // gate outputs
    input wire logic                                    gate_a_high_pin,
    input wire logic                                    gate_a_low_pin,
    input wire logic                                    gate_b_high_pin,
    input wire logic                                    gate_b_low_pin,
    input wire logic                                    gate_c_high_pin,
    input wire logic                                    gate_c_low_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cfg;
    logic       hw;
    // shadow of the stored config bits
    always_ff @(posedge clk_sys) begin
        if (rst)
            cfg <= 8'h00;
        else if (reg_wr && reg_addr == motor_mask_pkg::OFS_CONFIG)
            cfg <= reg_wdata & 8'h8F;
    end
    // normal mode with hardware masking
    assign hw = !brake_request && !protect_trip && !cfg[7];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_brake_wins: assert property (
        brake_request |=> {gate_a_high_pin, gate_b_high_pin, gate_c_high_pin, gate_a_low_pin,
        gate_b_low_pin, gate_c_low_pin} == 6'h07) else $error("brake did not force gates");
    chk_protect_style: assert property (
        protect_trip && !brake_request |=> {gate_a_high_pin, gate_b_high_pin, gate_c_high_pin} == 3'h0
        && {gate_a_low_pin, gate_b_low_pin, gate_c_low_pin} == {3{$past(cfg[1])}}) else $error("protect levels");
    chk_equal_off: assert property (
        hw && phase_cmd[0].high == phase_cmd[0].low |=> !gate_a_high_pin && !gate_a_low_pin)
        else $error("equal commands not off");
    chk_static_high: assert property (
        hw && !cfg[0] && phase_cmd[1] == 2'h2 |=> gate_b_high_pin && !gate_b_low_pin)
        else $error("static high level");
    chk_comp_low: assert property (
        hw && cfg[3:2] == 2'h1 && !cfg[0] && phase_cmd[2] == 2'h1 |=> gate_c_high_pin == $past(pwm_chan[2].inv_out)
        && gate_c_low_pin == $past(pwm_chan[2].true_out)) else $error("complementary low side");
    chk_comp_high: assert property (
        hw && cfg[3:2] == 2'h1 && cfg[0] && phase_cmd[0] == 2'h2 |=> gate_a_high_pin == $past(pwm_chan[0].true_out)
        && gate_a_low_pin == $past(pwm_chan[0].inv_out)) else $error("complementary high side");
    chk_noncomp_low: assert property (
        hw && cfg[3:2] == 2'h3 && !cfg[0] && phase_cmd[1] == 2'h1 |=> !gate_b_high_pin
        && gate_b_low_pin == $past(pwm_chan[1].true_out)) else $error("non-complementary low side");
    chk_noncomp_high: assert property (
        hw && cfg[3:2] == 2'h3 && cfg[0] && phase_cmd[2] == 2'h2 |=> !gate_c_low_pin
        && gate_c_high_pin == $past(pwm_chan[2].true_out)) else $error("non-complementary high side");
    chk_pwm_off: assert property (
        hw && !cfg[2] && !cfg[0] && phase_cmd[0] == 2'h1 |=> !gate_a_high_pin && gate_a_low_pin)
        else $error("pwm reached gates while disabled");
    chk_status_read: assert property (
        $past(reg_rd) && $past(reg_addr) == motor_mask_pkg::OFS_STATUS |-> reg_rdata == {2'h0,
        $past(gate_a_high_pin), $past(gate_a_low_pin), $past(gate_b_high_pin), $past(hall_filtered)})
        else $error("status read value");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
endmodule // motor_gate_mask_steering_monitor
bind motor_gate_mask_steering motor_gate_mask_steering_monitor #(.PHASES(PHASES)) u_monitor (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .phase_cmd, .pwm_chan,
    .brake_request, .protect_trip, .hall_filtered, .gate_a_high_pin, .gate_a_low_pin,
    .gate_b_high_pin, .gate_b_low_pin, .gate_c_high_pin, .gate_c_low_pin);

// ===== dv/motor_gate_mask_steering_tb.sv
// self-checking testbench for the gate mask steering block
module motor_gate_mask_steering_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                                  clk_sys = 1'h0;
    logic                                  rst, reg_wr, reg_rd, brake_request, protect_trip, shoot_through;
    logic [motor_mask_pkg::ADDR_W-1:0]     reg_addr;
    logic [7:0]                            reg_wdata, reg_rdata, rd_val;
    logic [2:0]                            hall_filtered;
    logic [5:0]                            gates;
    motor_mask_pkg::phase_cmd_t [2:0]      phase_cmd;
    motor_mask_pkg::pwm_pair_t  [2:0]      pwm_chan;
    int                                    fails, samples_checked;

    motor_gate_mask_steering dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_cmd(phase_cmd), .pwm_chan(pwm_chan),
        .brake_request(brake_request), .protect_trip(protect_trip), .hall_filtered(hall_filtered),
        .gate_a_high_pin(gates[1]), .gate_a_low_pin(gates[0]), .gate_b_high_pin(gates[3]),
        .gate_b_low_pin(gates[2]), .gate_c_high_pin(gates[5]), .gate_c_low_pin(gates[4]));
    gate_driver_model u_driver (.clk_sys(clk_sys), .rst(rst), .gate_levels(gates), .shoot_through(shoot_through));

    // 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask

    // read data stand in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 rd_val = reg_rdata;
    endtask

    // drive mode, commands and pwm, then wait the one registered cycle
    task automatic apply(input logic [1:0] m, input logic [5:0] c, input logic [5:0] p);
        @(posedge clk_sys);
        {brake_request, protect_trip} <= m;
        phase_cmd <= c;
        pwm_chan <= p;
        @(posedge clk_sys);
        #1;
    endtask

    // expected {high,low} of one phase in normal mode
    function automatic logic [1:0] exp_gate(input logic [1:0] c, input logic [1:0] p, input logic [7:0] cfg);
        logic t, i;
        t = cfg[2] ? p[1] : 1'h1;
        i = cfg[2] ? p[0] : 1'h0;
        if (c[1] == c[0])
            return 2'h0;
        if (!cfg[0])
            return c[1] ? 2'h2 : {cfg[3] ? 1'h0 : i, t};
        return c[0] ? 2'h1 : {t, cfg[3] ? 1'h0 : i};
    endfunction

    task automatic sweep(input logic [7:0] cfg);
        for (int k = 0; k < 16; k++) begin
            // pwm pairs stay complementary, as a real generator drives them
            apply(2'h0, {2'(k + 2), 2'(k + 1), 2'(k)}, {k[3] ? 2'h1 : 2'h2, k[2] ? 2'h2 : 2'h1, k[2] ? 2'h1 : 2'h2});
            for (int x = 0; x < 3; x++)
                check({6'h00, gates[2*x+:2]}, {6'h00, exp_gate(phase_cmd[x], pwm_chan[x], cfg)});
        end
    endtask

    task automatic test_regs;
        rd(motor_mask_pkg::OFS_CONFIG);
        check(rd_val, 8'h00);
        wr(motor_mask_pkg::OFS_STATUS, 8'hFF);
        rd(motor_mask_pkg::OFS_STATUS);
        check(rd_val, 8'h02);
        wr(motor_mask_pkg::OFS_CONFIG, 8'hFF);
        rd(motor_mask_pkg::OFS_CONFIG);
        check(rd_val, 8'h8F);
        for (int r = 2; r < 4; r++) begin
            rd(4'(r));
            check(rd_val, 8'h00);
            wr(4'(r), 8'hFF);
            rd(4'(r));
            check(rd_val, 8'h3F);
            wr(4'(r), 8'h00);
        end
        wr(4'hF, 8'hFF);
        rd(4'hF);
        check(rd_val, 8'h00);
        $display("test_regs done");
    endtask

    task automatic test_hw;
        for (int c = 0; c < 16; c++) begin
            wr(motor_mask_pkg::OFS_CONFIG, {4'h0, 4'(c)});
            sweep({4'h0, 4'(c)});
        end
        $display("test_hw done");
    endtask

    // software masking ignores pair style; masked pair follows the data, both masked high forced off
    task automatic test_soft;
        wr(motor_mask_pkg::OFS_CONFIG, 8'h8D);
        sweep(8'h85);
        wr(motor_mask_pkg::OFS_MASK_ENABLE, 8'h03);
        wr(motor_mask_pkg::OFS_MASK_DATA, 8'h02);
        apply(2'h0, 6'h00, 6'h00);
        check({6'h00, gates[1:0]}, 8'h01);
        wr(motor_mask_pkg::OFS_MASK_DATA, 8'h03);
        apply(2'h0, 6'h00, 6'h00);
        check({6'h00, gates[1:0]}, 8'h00);
        wr(motor_mask_pkg::OFS_MASK_ENABLE, 8'h00);
        $display("test_soft done");
    endtask

    task automatic test_modes;
        for (int s = 0; s < 2; s++) begin
            wr(motor_mask_pkg::OFS_CONFIG, {6'h01, 1'(s), 1'h0});
            for (int m = 1; m < 4; m++) begin
                apply(2'(m), 6'h12, 6'h2A);
                check({2'h0, gates}, m > 1 ? 8'h15 : {2'h0, {3{1'h0, 1'(s)}}});
            end
        end
        apply(2'h0, 6'h00, 6'h00);
        $display("test_modes done");
    endtask

    task automatic test_status;
        wr(motor_mask_pkg::OFS_CONFIG, 8'h00);
        hall_filtered <= 3'h5;
        apply(2'h0, 6'h0A, 6'h00);
        rd(motor_mask_pkg::OFS_STATUS);
        check(rd_val, 8'h2D);
        $display("test_status done");
    endtask

    // watchdog against a hang
    initial begin
        #500000;
        fails++;
        end_sim();
    end

    initial begin
        rst = 1'h1;
        {reg_wr, reg_rd, brake_request, protect_trip} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        hall_filtered = 3'h2;
        phase_cmd = 6'h00;
        pwm_chan = 6'h00;
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        test_regs();
        test_hw();
        test_soft();
        test_modes();
        test_status();
        check({7'h00, shoot_through}, 8'h00);
        end_sim();
    end
endmodule // motor_gate_mask_steering_tb
